// >>> bench/scu_line_partner.sv
// remote uart on the far side of the serial lines
`timescale 1ns/1ps
module scu_line_partner #(
    parameter int BIT = 16
) (
    input wire logic sys_clk,
    input wire logic lineIn,
    output logic lineOut
);
    // line rests high between characters
    initial lineOut = 1'b1;
    // start, eight data bits lsb first, one stop of chosen level
    task automatic send(input logic [7:0] b, input logic stopLvl);
        logic [9:0] f;
        f = {stopLvl, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            lineOut <= f[i];
            repeat (BIT) @(posedge sys_clk);
        end
        lineOut <= 1'b1;
    endtask : send
    // find the start bit, then sample each data bit mid-cell
    task automatic recv(output logic [7:0] b);
        @(negedge lineIn);
        repeat (BIT / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge sys_clk);
            b[i] = lineIn;
        end
    endtask : recv
endmodule : scu_line_partner

// >>> bench/test_serial_channel_async_uart.sv
// self-checking bench for the asynchronous uart channel
`timescale 1ns/1ps
`include "scu_cfg.svh"
module test_serial_channel_async_uart;
    import scu_pkg::*;
    logic sys_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, serialOut, serialIn;
    logic [1:0] bresp, rresp, rs;
    logic [3:0] wstrb;
    scu_addr_t awaddr, araddr;
    scu_word_t wdata, rdata, rd;
    logic [7:0] got;
    logic rtsOut_n, wake;
    int wakes = 0;
    int fail_count = 0, num_checks = 0, seed = 98615, q[$];
    // device with modem pins held active and internal clocks
    scu_uart scu_uart_i (.sys_clk(sys_clk), .reset_n(reset_n), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .serialOut(serialOut), .serialIn(serialIn), .rx_bit_clock(1'b0),
        .tx_bit_clock(1'b0), .carrier_detect_pin_n(1'b0), .clearToSend_n(1'b0),
        .requestToSend_n(rtsOut_n), .coreWake(wake));
    scu_line_partner scu_line_partner_i (.sys_clk(sys_clk), .lineIn(serialOut),
        .lineOut(serialIn));
    // count wake pulses of the sleeping receiver
    always @(posedge sys_clk) begin
        if (wake === 1'b1) wakes <= wakes + 1;
    end
    // 25 mhz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    function automatic int lfsr(input int s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // bus write, each channel released when taken
    task automatic wr(input scu_addr_t a, input scu_word_t d);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, wstrb == `SCU_STRB_ALL ? 32'h0 : 32'h2);
    endtask : wr
    // bus read, data and response kept in rd and rs
    task automatic rdr(input scu_addr_t a);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rdr
    // main sequence; the third received character has a zero stop bit
    initial begin
        {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = {5'h00, 5'h00, 32'h0, 4'hf};
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdr(`SCU_A_BAUD);
        chk("baud", rd, 32'h0000000c);
        rdr(`SCU_A_DESC);
        chk("desc", rd, 32'h00000000);
        wr(`SCU_A_BAUD, 32'h0);
        wr(`SCU_A_MODE, 32'h7);
        for (int n = 0; n < 3; n++) begin
            seed = lfsr(seed);
            q.push_back((seed & 8'hff) | 1);
            fork
                wr(`SCU_A_TXD, q[$]);
                scu_line_partner_i.recv(got);
            join
            chk("txchar", {24'h0, got}, q[$]);
            scu_line_partner_i.send(q[$], n != 2);
            repeat (20) @(posedge sys_clk);
            rdr(`SCU_A_RXD);
            chk("rxchar", rd, 32'h1000 | (n == 2 ? 32'h400 : 0) | q[$]);
        end
        // all-zero character with a zero stop is a break
        scu_line_partner_i.send(8'h00, 1'b0);
        repeat (20) @(posedge sys_clk);
        rdr(`SCU_A_RXD);
        chk("break", rd, 32'h00001800);
        // multidrop: halt, disable, resume and hunt, re-enable
        wr(`SCU_A_CMD, 32'h1);
        wr(`SCU_A_MODE, 32'h24);
        wr(`SCU_A_CMD, 32'h6);
        wr(`SCU_A_MODE, 32'h27);
        // partner stop level lands in the address bit position
        scu_line_partner_i.send(8'h5a, 1'b0);
        repeat (20) @(posedge sys_clk);
        rdr(`SCU_A_STAT);
        chk("sleep", rd, 32'h00000040);
        scu_line_partner_i.send(8'ha5, 1'b1);
        repeat (20) @(posedge sys_clk);
        chk("wake", wakes, 1);
        rdr(`SCU_A_RXD);
        chk("addr", rd, 32'h000011a5);
        // halted transmitter keeps its character while the line goes quiet
        wr(`SCU_A_CMD, 32'h1);
        wr(`SCU_A_TXD, 32'h55);
        repeat (200) @(posedge sys_clk);
        rdr(`SCU_A_STAT);
        chk("stat", rd, 32'h00000091);
        chk("rts", {31'h0, rtsOut_n}, 32'h1);
        wr(`SCU_A_CMD, 32'h2);
        scu_line_partner_i.recv(got);
        chk("txchar", {24'h0, got}, 32'h55);
        chk("rts", {31'h0, rtsOut_n}, 32'h0);
        repeat (60) @(posedge sys_clk);
        rdr(`SCU_A_ERRC);
        chk("errc", rd, 32'h00010000);
        wr(`SCU_A_MODE, 32'h0);
        rdr(`SCU_A_DESC);
        chk("desc", rd, 32'h00000202);
        rdr(5'h02);
        chk("resp", {30'h0, rs}, 32'h2);
        wr(`SCU_A_CMD, 32'h8);
        rdr(`SCU_A_BAUD);
        chk("baud", rd, 32'h0000000c);
        wstrb <= 4'h3;
        wr(`SCU_A_BAUD, 32'h1);
        rdr(`SCU_A_BAUD);
        chk("baud", rd, 32'h0000000c);
        end_sim;
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        end_sim;
    end
endmodule : test_serial_channel_async_uart

// >>> hw/scu_cfg.svh
// register map, field positions, reset values and timing constants of the uart channel
`ifndef SCU_CFG_SVH
`define SCU_CFG_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define SCU_A_MODE 5'h00
`define SCU_A_CMD 5'h04
`define SCU_A_BAUD 5'h08
`define SCU_A_TXD 5'h0c
`define SCU_A_RXD 5'h10
`define SCU_A_STAT 5'h14
`define SCU_A_ERRC 5'h18
`define SCU_A_DESC 5'h1c

// ****************************************************************
// channel mode register fields
// ****************************************************************
`define SCU_M_TXEN 0
`define SCU_M_RXEN 1
`define SCU_M_LEN8 2
`define SCU_M_PAREN 3
`define SCU_M_PARODD 4
`define SCU_M_MDROP 5
`define SCU_M_STOP2 6
`define SCU_M_BRK 7
`define SCU_M_TXPIN 8
`define SCU_M_RXPIN 9
`define SCU_M_SWCD 10
`define SCU_MODE_W 11
`define SCU_MODE_RST 11'h000

// ****************************************************************
// command register bits
// ****************************************************************
`define SCU_C_HALT 0
`define SCU_C_RESUME 1
`define SCU_C_HUNT 2
`define SCU_C_CPRST 3

// ****************************************************************
// status and data field positions, resets
// ****************************************************************
`define SCU_TXD_ADDR 8
`define SCU_RXD_VALID 12
`define SCU_BAUD_RST 16'h000c
`define SCU_DESC_RST 8'h00
`define SCU_LEN8 4'h8
`define SCU_LEN7 4'h7

// ****************************************************************
// sixteen-times sample points
// ****************************************************************
`define SCU_S_LO 4'h7
`define SCU_S_MID 4'h8
`define SCU_S_HI 4'h9
`define SCU_S_TAIL 4'ha
`define SCU_S_LAST 4'hf

// ****************************************************************
// bus answers
// ****************************************************************
`define SCU_OKAY 2'h0
`define SCU_SLVERR 2'h2
`define SCU_STRB_ALL 4'hf

`endif

// >>> hw/scu_pkg.sv
// types shared by the uart channel design
package scu_pkg;
    typedef logic [4:0] scu_addr_t;
    typedef logic [31:0] scu_word_t;
    typedef enum logic [1:0] {RX_OFF, RX_WAIT, RX_BIT, RX_TAIL} scu_rx_e;
    typedef enum logic {TX_IDLE, TX_RUN} scu_tx_e;
endpackage : scu_pkg

// >>> hw/scu_sync2.sv
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module scu_sync2 #(
    parameter bit INIT = 1'b1
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic pinIn,
    output logic syncOut
);
    logic meta_q;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= INIT;
            syncOut <= INIT;
        end else begin
            meta_q <= pinIn;
            syncOut <= meta_q;
        end
    end
endmodule : scu_sync2

// >>> hw/scu_uart.sv
// asynchronous uart channel with axi4-lite register slave
`timescale 1ns/1ps
`include "scu_cfg.svh"

module scu_uart (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic awvalid,
    output logic awready,
    input wire scu_pkg::scu_addr_t awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire scu_pkg::scu_word_t wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire scu_pkg::scu_addr_t araddr,
    output logic rvalid,
    input wire logic rready,
    output scu_pkg::scu_word_t rdata,
    output logic [1:0] rresp,
    output logic serialOut,
    input wire logic serialIn,
    input wire logic rx_bit_clock,
    input wire logic tx_bit_clock,
    input wire logic carrier_detect_pin_n,
    input wire logic clearToSend_n,
    output logic requestToSend_n,
    output logic coreWake
);
    import scu_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [`SCU_MODE_W-1:0] mode_q;
    logic [15:0] baudDiv_q, baudCnt_q, noiseCnt_q, frameCnt_q;
    logic [7:0] txDesc_q, rxDesc_q, quietCnt_q;
    logic awHave_q, wHave_q, cpRst_q, halt_q, sleep_q, quietFlag_q;
    scu_addr_t awAddr_q;
    scu_word_t wData_q;
    logic [3:0] wStrb_q;
    logic [8:0] txHold_q, txDat_q;
    logic holdFull_q, txPar_q, txUsed_q, rxUsed_q, txEnPrev_q, rxEnPrev_q;
    logic rxValid_q, s0_q, s1_q;
    logic [11:0] rxHold_q;
    logic [11:0] rxBits_q;
    logic [3:0] rxSmp_q, rxIdx_q, txSmp_q, txIdx_q;
    logic rclkPrev_q, tclkPrev_q;
    scu_rx_e rxSt_q;
    scu_tx_e txSt_q;
    logic rxIn, rclkS, tclkS, cdS, ctsS;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    scu_sync2 #(.INIT(1'b1)) syRxd (.sys_clk(sys_clk), .reset_n(reset_n),
        .pinIn(serialIn), .syncOut(rxIn));
    scu_sync2 #(.INIT(1'b0)) syRclk (.sys_clk(sys_clk), .reset_n(reset_n),
        .pinIn(rx_bit_clock), .syncOut(rclkS));
    scu_sync2 #(.INIT(1'b0)) syTclk (.sys_clk(sys_clk), .reset_n(reset_n),
        .pinIn(tx_bit_clock), .syncOut(tclkS));
    scu_sync2 #(.INIT(1'b1)) syCd (.sys_clk(sys_clk), .reset_n(reset_n),
        .pinIn(carrier_detect_pin_n), .syncOut(cdS));
    scu_sync2 #(.INIT(1'b1)) syCts (.sys_clk(sys_clk), .reset_n(reset_n),
        .pinIn(clearToSend_n), .syncOut(ctsS));

    // ****************************************************************
    // decode and datapath wires
    // ****************************************************************
    wire txEn = mode_q[`SCU_M_TXEN];
    wire rxEn = mode_q[`SCU_M_RXEN];
    wire md = mode_q[`SCU_M_MDROP];
    wire parEn = mode_q[`SCU_M_PAREN];
    wire parOdd = mode_q[`SCU_M_PARODD];
    wire [3:0] nBits = mode_q[`SCU_M_LEN8] ? `SCU_LEN8 : `SCU_LEN7;
    wire [3:0] rxLast = nBits + {3'h0, md} + {3'h0, parEn} + 4'h1;
    wire [3:0] txLast = rxLast + {3'h0, mode_q[`SCU_M_STOP2]};
    wire baudTick = baudCnt_q >= baudDiv_q; // a smaller divisor never strands the counter
    // each direction picks its own sixteen-times clock
    wire rxTick = mode_q[`SCU_M_RXPIN] ? (rclkS & ~rclkPrev_q) : baudTick;
    wire txTick = mode_q[`SCU_M_TXPIN] ? (tclkS & ~tclkPrev_q) : baudTick;
    wire wrFire = awHave_q & wHave_q & ~bvalid;
    wire wrOk = wrFire & (wStrb_q == `SCU_STRB_ALL);
    wire wrMap = awAddr_q <= `SCU_A_DESC && awAddr_q[1:0] == 2'h0;
    wire wMode = wrOk & awAddr_q == `SCU_A_MODE;
    wire wCmd = wrOk & awAddr_q == `SCU_A_CMD;
    wire wTx = wrOk & awAddr_q == `SCU_A_TXD;
    wire rdFire = arvalid & arready;
    wire rdMap = araddr <= `SCU_A_DESC && araddr[1:0] == 2'h0;
    wire rdRx = rdFire & araddr == `SCU_A_RXD;
    wire vote = (s0_q & s1_q) | (s0_q & rxIn) | (s1_q & rxIn);
    wire noise = ~((s0_q == s1_q) & (s1_q == rxIn));
    wire rxSamp = rxSt_q == RX_BIT & rxTick & rxSmp_q == `SCU_S_HI;
    wire rxDone = rxSamp & rxIdx_q == rxLast & rxIdx_q != 4'h0;
    wire [11:0] parMask = ((12'h1 << rxLast) - 12'h1) & ~12'h1;
    wire brk = (rxBits_q & parMask) == 12'h0 & ~vote;
    wire frameErr = ~vote & ~brk;
    wire parErr = parEn & ((^(rxBits_q & parMask)) != parOdd);
    wire rxAddr = md & rxBits_q[nBits + 4'h1];
    wire [7:0] rxData = rxBits_q[8:1] & {~nBits[0], 7'h7f};
    wire accept = rxDone & (~sleep_q | rxAddr);
    wire [7:0] frameTicks = {rxLast + 4'h1, 4'h0};
    wire quietRise = rxTick & rxIn & quietCnt_q == frameTicks & ~quietFlag_q;
    wire quietOut = (~mode_q[`SCU_M_SWCD] & cdS) | quietFlag_q;
    wire txLoad = txSt_q == TX_IDLE & txEn & holdFull_q & ~halt_q & ~ctsS;
    wire [8:0] txShift = txDat_q >> (txIdx_q - 4'h1);
    wire txBit = txIdx_q == 4'h0 ? 1'b0 :
        txIdx_q <= nBits ? txShift[0] :
        (md & txIdx_q == nBits + 4'h1) ? txDat_q[`SCU_TXD_ADDR] :
        (parEn & txIdx_q == nBits + 4'h1 + {3'h0, md}) ? txPar_q : 1'b1;
    wire [8:0] holdMask = {md, ~nBits[0], 7'h7f};
    wire holdPar = ^(txHold_q & holdMask) ^ parOdd;
    wire [31:0] rdMux =
        araddr == `SCU_A_MODE ? {21'h0, mode_q} :
        araddr == `SCU_A_BAUD ? {16'h0, baudDiv_q} :
        araddr == `SCU_A_TXD ? {23'h0, txHold_q} :
        araddr == `SCU_A_RXD ? {19'h0, rxValid_q, rxHold_q} :
        araddr == `SCU_A_STAT ? {24'h0, halt_q, sleep_q, rxValid_q, holdFull_q,
            txSt_q == TX_RUN, ctsS, cdS, quietOut} :
        araddr == `SCU_A_ERRC ? {frameCnt_q, noiseCnt_q} :
        araddr == `SCU_A_DESC ? {16'h0, rxDesc_q, txDesc_q} : 32'h0;

    // ****************************************************************
    // axi4-lite slave handshakes
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `SCU_OKAY;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `SCU_OKAY;
            arready <= 1'b1;
        end else begin
            if (awvalid & awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= awaddr;
            end else if (wrFire) begin
                awHave_q <= 1'b0;
            end
            if (wvalid & wready) begin
                wHave_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end else if (wrFire) begin
                wHave_q <= 1'b0;
            end
            if (wrFire) begin
                bvalid <= 1'b1;
                bresp <= (wrMap & wStrb_q == `SCU_STRB_ALL) ? `SCU_OKAY : `SCU_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            if (rdFire) begin
                rvalid <= 1'b1;
                arready <= 1'b0;
                rdata <= rdMux;
                rresp <= rdMap ? `SCU_OKAY : `SCU_SLVERR;
            end else if (rvalid & rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
    assign awready = ~awHave_q;
    assign wready = ~wHave_q;

    // ****************************************************************
    // software registers, command reset and buffer closing
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `SCU_MODE_RST;
            baudDiv_q <= `SCU_BAUD_RST;
            cpRst_q <= 1'b0;
            halt_q <= 1'b0;
            txDesc_q <= `SCU_DESC_RST;
            rxDesc_q <= `SCU_DESC_RST;
            txEnPrev_q <= 1'b0;
            rxEnPrev_q <= 1'b0;
        end else if (cpRst_q) begin
            mode_q <= `SCU_MODE_RST;
            baudDiv_q <= `SCU_BAUD_RST;
            cpRst_q <= 1'b0;
            halt_q <= 1'b0;
            txDesc_q <= `SCU_DESC_RST;
            rxDesc_q <= `SCU_DESC_RST;
            txEnPrev_q <= 1'b0;
            rxEnPrev_q <= 1'b0;
        end else begin
            txEnPrev_q <= txEn;
            rxEnPrev_q <= rxEn;
            if (wMode) mode_q <= wData_q[`SCU_MODE_W-1:0];
            if (wrOk & awAddr_q == `SCU_A_BAUD) baudDiv_q <= wData_q[15:0];
            cpRst_q <= wCmd & wData_q[`SCU_C_CPRST];
            if (wCmd & wData_q[`SCU_C_HALT]) halt_q <= 1'b1;
            else if (wCmd & wData_q[`SCU_C_RESUME]) halt_q <= 1'b0;
            // indices survive disable; a used buffer is closed
            if (wrOk & awAddr_q == `SCU_A_DESC) begin
                txDesc_q <= wData_q[7:0];
                rxDesc_q <= wData_q[15:8];
            end else begin
                if (txEnPrev_q & ~txEn & txUsed_q) txDesc_q <= txDesc_q + 8'h1;
                if (rxEnPrev_q & ~rxEn & rxUsed_q) rxDesc_q <= rxDesc_q + 8'h1;
            end
        end
    end

    // baud generator and pin clock edge history
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            baudCnt_q <= 16'h0;
            rclkPrev_q <= 1'b0;
            tclkPrev_q <= 1'b0;
        end else begin
            baudCnt_q <= (baudTick | cpRst_q) ? 16'h0 : baudCnt_q + 16'h1;
            rclkPrev_q <= rclkS;
            tclkPrev_q <= tclkS;
        end
    end

    // ****************************************************************
    // receiver sequencer: sixteen ticks per bit, vote at centre
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxSt_q <= RX_OFF;
            rxSmp_q <= 4'h0;
            rxIdx_q <= 4'h0;
            rxBits_q <= 12'h0;
            s0_q <= 1'b1;
            s1_q <= 1'b1;
        end else if (cpRst_q | ~rxEn) begin
            rxSt_q <= RX_OFF;
            rxSmp_q <= 4'h0;
            rxIdx_q <= 4'h0;
        end else begin
            case (rxSt_q)
                RX_OFF: rxSt_q <= RX_WAIT;
                RX_WAIT: if (rxTick & ~rxIn) begin
                    rxSt_q <= RX_BIT;
                    rxSmp_q <= 4'h0;
                    rxIdx_q <= 4'h0;
                end
                RX_BIT: if (rxTick) begin
                    rxSmp_q <= rxSmp_q + 4'h1;
                    if (rxSmp_q == `SCU_S_LO) s0_q <= rxIn;
                    if (rxSmp_q == `SCU_S_MID) s1_q <= rxIn;
                    if (rxSmp_q == `SCU_S_HI) begin
                        rxBits_q[rxIdx_q] <= vote;
                        if (rxIdx_q == 4'h0 & vote) rxSt_q <= RX_WAIT;
                        else if (rxIdx_q == rxLast) rxSt_q <= RX_TAIL;
                    end
                    if (rxSmp_q == `SCU_S_LAST) rxIdx_q <= rxIdx_q + 4'h1;
                end
                RX_TAIL: if (rxTick) begin
                    rxSmp_q <= rxSmp_q + 4'h1;
                    if (rxSmp_q == `SCU_S_TAIL) rxSt_q <= RX_WAIT;
                end
                default: rxSt_q <= RX_OFF;
            endcase
        end
    end

    // receive holding, error counters, quiet line and wakeup
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxHold_q <= 12'h0;
            rxValid_q <= 1'b0;
            rxUsed_q <= 1'b0;
            noiseCnt_q <= 16'h0;
            frameCnt_q <= 16'h0;
            quietCnt_q <= 8'h0;
            quietFlag_q <= 1'b0;
            sleep_q <= 1'b0;
            coreWake <= 1'b0;
        end else if (cpRst_q) begin
            rxHold_q <= 12'h0;
            rxValid_q <= 1'b0;
            rxUsed_q <= 1'b0;
            noiseCnt_q <= 16'h0;
            frameCnt_q <= 16'h0;
            quietCnt_q <= 8'h0;
            quietFlag_q <= 1'b0;
            sleep_q <= 1'b0;
            coreWake <= 1'b0;
        end else begin
            if (accept) begin
                rxHold_q <= {brk, frameErr, parErr, rxAddr, rxData};
                rxUsed_q <= 1'b1;
            end else if (rxEnPrev_q & ~rxEn) begin
                rxUsed_q <= 1'b0;
            end
            rxValid_q <= accept | (rxValid_q & ~rdRx);
            if (rxSamp & noise) noiseCnt_q <= noiseCnt_q + 16'h1;
            if (rxDone & frameErr) frameCnt_q <= frameCnt_q + 16'h1;
            if (~rxEn) begin
                quietCnt_q <= 8'h0;
                quietFlag_q <= 1'b0;
            end else if (rxTick & ~rxIn) begin
                quietCnt_q <= 8'h0;
                quietFlag_q <= 1'b0;
            end else if (rxTick & quietCnt_q == frameTicks) begin
                quietFlag_q <= 1'b1;
            end else if (rxTick) begin
                quietCnt_q <= quietCnt_q + 8'h1;
            end
            if (wCmd & wData_q[`SCU_C_HUNT]) sleep_q <= md;
            else if (quietRise | (rxDone & rxAddr)) sleep_q <= 1'b0;
            coreWake <= sleep_q & rxEn & (quietRise | (rxDone & rxAddr));
        end
    end

    // ****************************************************************
    // transmitter
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txSt_q <= TX_IDLE;
            txSmp_q <= 4'h0;
            txIdx_q <= 4'h0;
            txDat_q <= 9'h0;
            txPar_q <= 1'b0;
            txHold_q <= 9'h0;
            holdFull_q <= 1'b0;
            txUsed_q <= 1'b0;
            serialOut <= 1'b1;
            requestToSend_n <= 1'b1;
        end else if (cpRst_q) begin
            txSt_q <= TX_IDLE;
            txSmp_q <= 4'h0;
            txIdx_q <= 4'h0;
            holdFull_q <= 1'b0;
            txUsed_q <= 1'b0;
            serialOut <= 1'b1;
            requestToSend_n <= 1'b1;
        end else begin
            if (wTx) begin
                txHold_q <= wData_q[8:0];
                holdFull_q <= 1'b1;
            end else if (txLoad) begin
                holdFull_q <= 1'b0;
            end
            if (~txEn) begin
                txSt_q <= TX_IDLE;
                txSmp_q <= 4'h0;
                txIdx_q <= 4'h0;
                if (txEnPrev_q) txUsed_q <= 1'b0;
            end else if (txLoad) begin
                txSt_q <= TX_RUN;
                txDat_q <= txHold_q & holdMask;
                txPar_q <= holdPar;
            end else if (txSt_q == TX_RUN & txTick) begin
                txSmp_q <= txSmp_q + 4'h1;
                if (txSmp_q == `SCU_S_LAST) begin
                    txIdx_q <= txIdx_q + 4'h1;
                    if (txIdx_q == txLast) begin
                        txSt_q <= TX_IDLE;
                        txIdx_q <= 4'h0;
                        txUsed_q <= 1'b1;
                    end
                end
            end
            // idle line is high, break forces a continuous low while the transmitter is enabled
            serialOut <= ~txEn | (~mode_q[`SCU_M_BRK] & (txSt_q != TX_RUN | txBit));
            requestToSend_n <= txSt_q != TX_RUN;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence sLoad;
        txLoad & ~mode_q[`SCU_M_BRK];
    endsequence
    sequence sStart;
        ##[1:2] ~serialOut;
    endsequence
    AST_START_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sLoad |-> sStart) else $error("start bit not driven low");
    AST_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (~txEn & ~cpRst_q) |=> serialOut) else $error("disabled line not high");
    AST_TX_PARK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ~txEn & ~txLoad |=> txSt_q == TX_IDLE && txSmp_q == 4'h0)
        else $error("disabled transmitter still running");
    AST_RX_PARK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ~rxEn |=> rxSt_q == RX_OFF) else $error("disabled receiver still running");
    AST_DESC_KEEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        txEnPrev_q & ~txEn & ~txUsed_q & ~wrOk & ~cpRst_q |=> $stable(txDesc_q))
        else $error("disable moved descriptor index");
    AST_DESC_CLOSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        txEnPrev_q & ~txEn & txUsed_q & ~wrOk & ~cpRst_q
        |=> txDesc_q == $past(txDesc_q) + 8'h1) else $error("used buffer not closed");
    AST_CP_RESET: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cpRst_q |=> mode_q == `SCU_MODE_RST && ~holdFull_q && rxSt_q == RX_OFF)
        else $error("command reset incomplete");
    AST_NOISE_COUNT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rxSamp & noise & ~cpRst_q |=> noiseCnt_q == $past(noiseCnt_q) + 16'h1)
        else $error("noise not counted");
    AST_FRAME_COUNT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rxDone & frameErr & ~cpRst_q |=> frameCnt_q == $past(frameCnt_q) + 16'h1)
        else $error("framing error not counted");
endmodule : scu_uart
